//--- verilog/jt_pkg.sv
/*
 Shared constants, types and code tables of the link transmitter.
 Assumes one octet slot per lane per clock and an external serialiser.
*/
package jt_pkg;
    // ------------------------------------------------------------
    // Control characters and sequence figures
    // ------------------------------------------------------------
    localparam logic [7:0] K_COMMA = 8'hBC;
    localparam logic [7:0] K_ILA_START = 8'h1C;
    localparam logic [7:0] K_PARAM = 8'h9C;
    localparam logic [7:0] K_MF = 8'h7C;
    localparam logic [7:0] K_FRM = 8'hFC;
    localparam logic [1:0] ILA_LAST_MF = 2'h3;
    localparam int ILA_MF_NUM = 4;
    localparam logic [7:0] PARAM_POS = 8'h01;
    localparam logic [7:0] PARAM_NUM = 8'h0E;
    localparam int FCHK_NUM = 11;
    localparam int WORD_W = 16;
    localparam int ACC_W = 32;
    localparam logic [5:0] OCT_W = 6'h08;
    localparam logic [5:0] ACC_ROOM = 6'h10;
    localparam logic [4:0] SIMPLE_W = 5'h10;
    // ------------------------------------------------------------
    // Line code tables, negative running disparity forms
    // ------------------------------------------------------------
    localparam logic [5:0] K28_6B = 6'h0F;
    localparam logic [5:0] TAB6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29,
        6'h19, 6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B,
        6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36,
        6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] TAB4D [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    localparam logic [3:0] TAB4K [8] = '{4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'hA, 4'h6, 4'h8};
    localparam logic [3:0] ALT7 = 4'h7;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_CGS = 3'b001,
        ST_ILA = 3'b010,
        ST_DATA = 3'b100
    } jt_state_type;
    typedef struct packed {
        logic simple;
        logic scr_en;
        logic lane_sync_en;
        logic sync_is_divrst;
        logic [4:0] lanes_m1;
        logic [7:0] f_m1;
        logic [4:0] k_m1;
        logic [4:0] n_m1;
        logic [7:0] s_m1;
        logic [4:0] lid;
        logic [7:0] did;
    } jt_cfg_type;
    // Device id value is arbitrary
    localparam jt_cfg_type CFG_RESET = '{simple: 1'b0, scr_en: 1'b0, lane_sync_en: 1'b1,
        sync_is_divrst: 1'b0, lanes_m1: 5'h02, f_m1: 8'h06, k_m1: 5'h1F, n_m1: 5'h0D,
        s_m1: 8'h0B, lid: 5'h00, did: 8'h5A};
endpackage : jt_pkg

//--- verilog/jt_link_tx.sv
/*
 One lane of the converter link transmitter: comma phase, alignment
 sequence, sample packing, substitution, scrambler and line encoder.
 Assumes sample_data is synchronous to clk and a serialiser takes
 lane_code, bit 9 first, one code per clock.
*/
// Notes on behaviour
// RULE1: commas sent while sync request held
// RULE2: receiver releases request after code sync
// RULE3: alignment sequence is four multiframes of K
// RULE4: second multiframe carries the parameter set
// RULE5: alignment sequence carries standard marker characters
// RULE6: data starts right after alignment sequence
// RULE7: repeated frame end octet becomes frame marker
// RULE8: with lane sync, multiframe end uses other
// RULE9: scrambler present and can be bypassed
// RULE10: alignment sequence seeds the scrambler state
// RULE11: simple packing pads samples to 16 bits
// RULE12: simple mode frame rate equals sample rate; code gives this only when f_m1 is 1
// RULE13: efficient packing concatenates samples into octets
// RULE14: efficient frame rate is rational sample fraction
// RULE15: efficient after reset, reload selects simple
// RULE16: reduced lane counts and resolutions supported
// RULE17: system keeps lane rate within limits
// RULE18: sync release starts fixed depth sequence
// RULE19: sync pins optionally become divider reset
// RULE20: scrambler polynomial 1 + x^14 + x^15
// RULE21: standard K28 control character codes
// RULE22: every octet line coded with running disparity
`timescale 1ns/1ps
module jt_link_tx #(
    parameter int SAMPLE_W = 14
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sync_in_pos,
    input wire logic sync_in_neg,
    input wire logic cfg_load,
    input wire jt_pkg::jt_cfg_type cfg_in,
    input wire logic [SAMPLE_W-1:0] sample_data,
    input wire logic sample_valid,
    output logic sample_ready,
    output logic [9:0] lane_code,
    output logic frame_start,
    output jt_pkg::jt_state_type link_state,
    output logic clkdiv_rst,
    output jt_pkg::jt_cfg_type cfg_active
);
    if (SAMPLE_W < 8 || SAMPLE_W > jt_pkg::WORD_W) begin : g_bad_width
        $error("SAMPLE_W must lie in 8..16");
    end
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [10:0] enc_8b10b(input logic [7:0] d, input logic k,
        input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic r1;
        logic [4:0] x;
        logic [2:0] y;
        logic [9:0] code;
        x = d[4:0];
        y = d[7:5];
        r1 = rd;
        if (k) begin
            c6 = rd ? ~jt_pkg::K28_6B : jt_pkg::K28_6B; // RULE21
            c4 = rd ? ~jt_pkg::TAB4K[y] : jt_pkg::TAB4K[y];
        end else begin
            c6 = jt_pkg::TAB6[x];
            if (rd && ($countones(c6) != 3 || x == 5'h07)) begin
                c6 = ~c6;
            end
            r1 = rd ^ ($countones(c6) != 3);
            c4 = jt_pkg::TAB4D[y];
            // Alternate form avoids a run of five equal bits
            if (y == 3'h7 && ((!r1 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                (r1 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)))) begin
                c4 = jt_pkg::ALT7;
            end
            if (r1 && ($countones(c4) != 2 || y == 3'h3)) begin
                c4 = ~c4;
            end
        end
        code = {c6, c4};
        return {rd ^ ($countones(code) != 5), code}; // RULE22
    endfunction : enc_8b10b

    function automatic logic [22:0] scramble(input logic [14:0] st, input logic [7:0] d);
        logic [14:0] s;
        logic [7:0] o;
        s = st;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            o[i] = d[i] ^ s[14] ^ s[13]; // RULE20
            s = {s[13:0], o[i]};
        end
        return {s, o};
    endfunction : scramble

    function automatic logic [7:0] param_oct(input logic [3:0] idx,
        input jt_pkg::jt_cfg_type c);
        logic [4:0] np;
        np = c.simple ? 5'h0F : c.n_m1;
        unique case (idx)
            4'h0: return c.did;
            4'h2: return {3'h0, c.lid};
            4'h3: return {c.scr_en, 2'h0, c.lanes_m1};
            4'h4: return c.f_m1;
            4'h5: return {3'h0, c.k_m1};
            4'h7: return {3'h0, c.n_m1};
            4'h8: return {3'h0, np};
            4'h9: return c.s_m1;
            default: return 8'h00;
        endcase
    endfunction : param_oct
    // ------------------------------------------------------------
    // Link state, counters, packer and scrambler
    // ------------------------------------------------------------
    jt_pkg::jt_state_type state_reg, state_next;
    jt_pkg::jt_cfg_type cfg_reg, cfg_next;
    logic [7:0] oct_cnt_reg, oct_cnt_next, pos_reg, pos_next;
    logic [4:0] frm_cnt_reg, frm_cnt_next;
    logic [1:0] mf_cnt_reg, mf_cnt_next;
    logic [14:0] scr_reg, scr_next;
    logic [7:0] prev_reg, prev_next, oct_reg, oct_next;
    logic [jt_pkg::ACC_W-1:0] acc_reg, acc_next;
    logic [5:0] cnt_reg, cnt_next, cnt_pop;
    logic k_reg, k_next, div_reg, div_next, fs_reg, fs_next;
    logic sync_lvl, link_req, last_oct, last_frm, mf_last, emit, ila_end;
    logic [4:0] w;
    logic [7:0] pk_oct, d, fchk;
    logic [15:0] smp16, val;
    logic [22:0] sc;

    always_comb begin
        state_next = state_reg;
        oct_cnt_next = oct_cnt_reg;
        pos_next = pos_reg;
        frm_cnt_next = frm_cnt_reg;
        mf_cnt_next = mf_cnt_reg;
        scr_next = scr_reg;
        prev_next = prev_reg;
        acc_next = acc_reg;
        d = 8'h00;
        sc = 23'h0;
        fchk = 8'h00;
        for (int i = 0; i < jt_pkg::FCHK_NUM; i++) begin
            fchk = fchk + param_oct(4'(i), cfg_reg);
        end
        // Differential low means the receiver requests sync
        sync_lvl = ~sync_in_pos & sync_in_neg;
        link_req = sync_lvl & ~cfg_reg.sync_is_divrst; // RULE19
        div_next = sync_lvl & cfg_reg.sync_is_divrst; // RULE19
        cfg_next = cfg_load ? cfg_in : cfg_reg; // RULE15 RULE16
        last_oct = oct_cnt_reg == cfg_reg.f_m1;
        last_frm = frm_cnt_reg == cfg_reg.k_m1;
        mf_last = last_oct && last_frm;
        ila_end = state_reg == jt_pkg::ST_ILA && mf_last && mf_cnt_reg == jt_pkg::ILA_LAST_MF;
        // Simple words are 16 bits; efficient words are N bits wide
        w = cfg_reg.simple ? jt_pkg::SIMPLE_W : cfg_reg.n_m1 + 5'h01; // RULE11 RULE16
        emit = cnt_reg >= jt_pkg::OCT_W;
        pk_oct = emit ? 8'(acc_reg >> (cnt_reg - jt_pkg::OCT_W)) : 8'h00; // RULE13
        cnt_pop = emit ? cnt_reg - jt_pkg::OCT_W : cnt_reg;
        cnt_next = cnt_pop;
        sample_ready = (state_reg == jt_pkg::ST_DATA || ila_end) && cnt_pop <= jt_pkg::ACC_ROOM;
        smp16 = 16'(sample_data) << (jt_pkg::WORD_W - SAMPLE_W);
        val = smp16 >> (5'h10 - w); // RULE11 RULE16
        oct_next = jt_pkg::K_COMMA;
        k_next = 1'b1;
        unique case (state_reg)
            jt_pkg::ST_CGS: begin
                // Counters held at zero so every device starts alike
                oct_cnt_next = 8'h00; // RULE18
                pos_next = 8'h00;
                frm_cnt_next = 5'h00;
                mf_cnt_next = 2'h0;
                acc_next = '0;
                cnt_next = 6'h00;
                prev_next = 8'h00;
                oct_next = jt_pkg::K_COMMA; // RULE1
                if (!link_req) begin
                    state_next = jt_pkg::ST_ILA; // RULE18
                end
            end
            jt_pkg::ST_ILA: begin
                cnt_next = 6'h00;
                if (oct_cnt_reg == 8'h00 && frm_cnt_reg == 5'h00) begin
                    oct_next = jt_pkg::K_ILA_START; // RULE5
                end else if (mf_last) begin
                    oct_next = jt_pkg::K_MF; // RULE5
                end else if (mf_cnt_reg == 2'h1 && pos_reg == jt_pkg::PARAM_POS) begin
                    oct_next = jt_pkg::K_PARAM; // RULE4
                end else begin
                    k_next = 1'b0;
                    oct_next = pos_reg;
                    if (mf_cnt_reg == 2'h1 && pos_reg > jt_pkg::PARAM_POS &&
                        pos_reg <= jt_pkg::PARAM_NUM + jt_pkg::PARAM_POS) begin
                        oct_next = (pos_reg == jt_pkg::PARAM_NUM + jt_pkg::PARAM_POS) ?
                            fchk : param_oct(4'(pos_reg - 8'h02), cfg_reg); // RULE4
                    end
                    sc = scramble(scr_reg, oct_next);
                    if (cfg_reg.scr_en) begin
                        scr_next = sc[22:8]; // RULE10
                    end
                end
                // Preload one sample, else a filler octet skews every frame map
                if (ila_end) begin
                    state_next = jt_pkg::ST_DATA; // RULE3 RULE6
                    if (sample_valid) begin
                        acc_next = jt_pkg::ACC_W'(val); // RULE11 RULE13
                        cnt_next = 6'(w);
                    end
                end
            end
            jt_pkg::ST_DATA: begin
                sc = scramble(scr_reg, pk_oct);
                d = cfg_reg.scr_en ? sc[7:0] : pk_oct; // RULE9
                if (cfg_reg.scr_en) begin
                    scr_next = sc[22:8];
                end
                k_next = 1'b0;
                oct_next = d; // RULE6
                if (last_oct) begin
                    prev_next = d;
                    if (d == prev_reg) begin
                        k_next = 1'b1;
                        oct_next = (last_frm && cfg_reg.lane_sync_en) ?
                            jt_pkg::K_MF : jt_pkg::K_FRM; // RULE7 RULE8
                    end
                end
                // Frame rate follows from octets per frame: 1:1 simple only with f_m1 of 1
                if (sample_valid && sample_ready) begin
                    acc_next = (acc_reg << w) | jt_pkg::ACC_W'(val); // RULE12 RULE14
                    cnt_next = cnt_pop + 6'(w);
                end
            end
        endcase
        if (state_reg != jt_pkg::ST_CGS) begin
            oct_cnt_next = last_oct ? 8'h00 : oct_cnt_reg + 8'h01;
            pos_next = mf_last ? 8'h00 : pos_reg + 8'h01;
            frm_cnt_next = last_oct ? (last_frm ? 5'h00 : frm_cnt_reg + 5'h01) : frm_cnt_reg;
            mf_cnt_next = mf_last ? mf_cnt_reg + 2'h1 : mf_cnt_reg; // RULE3
            if (link_req) begin
                state_next = jt_pkg::ST_CGS; // RULE1
            end
        end
        fs_next = state_reg == jt_pkg::ST_DATA && oct_cnt_reg == 8'h00;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= jt_pkg::ST_CGS;
            cfg_reg <= jt_pkg::CFG_RESET; // RULE15
            oct_cnt_reg <= 8'h00;
            pos_reg <= 8'h00;
            frm_cnt_reg <= 5'h00;
            mf_cnt_reg <= 2'h0;
            scr_reg <= 15'h0;
            prev_reg <= 8'h00;
            acc_reg <= '0;
            cnt_reg <= 6'h00;
            oct_reg <= jt_pkg::K_COMMA;
            k_reg <= 1'b1;
            div_reg <= 1'b0;
            fs_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cfg_reg <= cfg_next;
            oct_cnt_reg <= oct_cnt_next;
            pos_reg <= pos_next;
            frm_cnt_reg <= frm_cnt_next;
            mf_cnt_reg <= mf_cnt_next;
            scr_reg <= scr_next;
            prev_reg <= prev_next;
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
            oct_reg <= oct_next;
            k_reg <= k_next;
            div_reg <= div_next;
            fs_reg <= fs_next;
        end
    end
    // ------------------------------------------------------------
    // Line encoder
    // ------------------------------------------------------------
    logic [9:0] code_reg, code_next;
    logic rd_reg, rd_next;

    always_comb begin
        {rd_next, code_next} = enc_8b10b(oct_reg, k_reg, rd_reg); // RULE22
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            code_reg <= 10'h0FA;
            rd_reg <= 1'b1;
        end else begin
            code_reg <= code_next;
            rd_reg <= rd_next;
        end
    end

    assign lane_code = code_reg;
    assign frame_start = fs_reg;
    assign link_state = state_reg;
    assign clkdiv_rst = div_reg;
    assign cfg_active = cfg_reg;
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [15:0] ila_len_reg;
    logic [15:0] ila_want;
    always_ff @(posedge clk) begin
        if (sys_rst || state_reg != jt_pkg::ST_ILA) begin
            ila_len_reg <= 16'h0;
        end else begin
            ila_len_reg <= ila_len_reg + 16'h1;
        end
    end
    assign ila_want = 16'(jt_pkg::ILA_MF_NUM) * (16'(cfg_reg.k_m1) + 16'h1) *
        (16'(cfg_reg.f_m1) + 16'h1);

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_release;
        state_reg == jt_pkg::ST_CGS && !link_req;
    endsequence
    sequence s_ila_opens;
        state_reg == jt_pkg::ST_ILA ##1 (k_reg && oct_reg == jt_pkg::K_ILA_START);
    endsequence

    chk_comma_out: assert property (state_reg == jt_pkg::ST_CGS && !$past(sys_rst) |=> // RULE1
        k_reg && oct_reg == jt_pkg::K_COMMA) else $error("comma missing");
    chk_release_seq: assert property (s_release |=> s_ila_opens) // RULE18
        else $error("release did not start sequence");
    chk_ila_length: assert property (state_reg == jt_pkg::ST_ILA && // RULE3
        state_next == jt_pkg::ST_DATA |-> ila_len_reg + 16'h1 == ila_want)
        else $error("alignment length wrong");
    chk_param_mark: assert property (state_reg == jt_pkg::ST_ILA && mf_cnt_reg == 2'h1 && // RULE4
        pos_reg == jt_pkg::PARAM_POS |=> k_reg && oct_reg == jt_pkg::K_PARAM)
        else $error("parameter marker missing");
    chk_ila_mf_end: assert property (state_reg == jt_pkg::ST_ILA && mf_last |=> // RULE5
        k_reg && oct_reg == jt_pkg::K_MF) else $error("multiframe end marker missing");
    chk_frame_sub: assert property (state_reg == jt_pkg::ST_DATA && last_oct && // RULE7
        !(last_frm && cfg_reg.lane_sync_en) && d == prev_reg |=>
        k_reg && oct_reg == jt_pkg::K_FRM) else $error("frame substitute missing");
    chk_mf_sub: assert property (state_reg == jt_pkg::ST_DATA && mf_last && // RULE8
        cfg_reg.lane_sync_en && d == prev_reg |=> k_reg && oct_reg == jt_pkg::K_MF)
        else $error("multiframe substitute missing");
    chk_code_balance: assert property (!$past(sys_rst) |-> // RULE22
        $countones(code_reg) >= 4 && $countones(code_reg) <= 6)
        else $error("line code unbalanced");
    chk_data_start: assert property (state_reg == jt_pkg::ST_ILA && // RULE6
        state_next == jt_pkg::ST_DATA && !link_req |=> state_reg == jt_pkg::ST_DATA ##1
        !k_reg || oct_reg == jt_pkg::K_FRM || oct_reg == jt_pkg::K_MF)
        else $error("data did not follow alignment");
    chk_divrst_hold: assert property (cfg_reg.sync_is_divrst && // RULE19
        state_reg == jt_pkg::ST_DATA |=> state_reg == jt_pkg::ST_DATA)
        else $error("divider reset mode disturbed link");
endmodule : jt_link_tx

//--- test/jt_rx_model.sv
/*
 Receiver-side model of the link: holds the sync request, counts commas
 and releases the request after four in a row, or at once while still locked.
 Assumes lane_code is registered on clk and hold_req comes from the bench.
*/
`timescale 1ns/1ps
module jt_rx_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [9:0] lane_code,
    input wire logic hold_req,
    output logic sync_in_pos,
    output logic sync_in_neg
);
    // ------------------------------------------------------------
    // Code group sync tracking
    // ------------------------------------------------------------
    logic [2:0] comma_cnt_reg, comma_cnt_next;
    logic released_reg, released_next;
    logic lock_reg, lock_next;
    logic is_comma;
    always_comb begin
        is_comma = (lane_code[9:3] == 7'h1F) || (lane_code[9:3] == 7'h60);
        comma_cnt_next = comma_cnt_reg;
        released_next = released_reg;
        lock_next = lock_reg;
        if (hold_req) begin
            comma_cnt_next = 3'h0;
            released_next = 1'b0;
            // Commas mean the far end restarted, so alignment is redone
            if (is_comma) begin
                lock_next = 1'b0;
            end
        end else if (!released_reg) begin
            // Still aligned when the pins only reset the divider
            if (lock_reg) begin
                released_next = 1'b1;
            end else if (!is_comma) begin
                comma_cnt_next = 3'h0;
            end else if (comma_cnt_reg == 3'h3) begin
                released_next = 1'b1;
                lock_next = 1'b1;
            end else begin
                comma_cnt_next = comma_cnt_reg + 3'h1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            comma_cnt_reg <= 3'h0;
            released_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else begin
            comma_cnt_reg <= comma_cnt_next;
            released_reg <= released_next;
            lock_reg <= lock_next;
        end
    end
    // Released pair idles high on the positive leg
    assign sync_in_pos = released_reg;
    assign sync_in_neg = ~released_reg;
endmodule : jt_rx_model

//--- test/test_jt_link_tx.sv
/*
 Self-checking bench of the link transmitter with a receiver model.
 Assumes the package constants and the one-lane transmitter top.
*/
`timescale 1ns/1ps
module test_jt_link_tx;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cfg_load = 1'b0;
    logic sample_valid = 1'b1;
    logic [13:0] sample_data = 14'h01A5;
    logic inc_mode = 1'b0;
    logic hold_req = 1'b1;
    jt_pkg::jt_cfg_type cfg_in = jt_pkg::CFG_RESET;
    jt_pkg::jt_cfg_type cfg_active, c;
    jt_pkg::jt_state_type link_state;
    logic sync_in_pos, sync_in_neg, sample_ready, frame_start, clkdiv_rst;
    logic [9:0] lane_code;
    int fail_count = 0;
    int cmp_count = 0;
    // One octet per clock stands in for a lane kept inside its rate limits
    always #12.5 clk = ~clk;
    jt_link_tx u_jt_link_tx (.clk(clk), .sys_rst(sys_rst), .sync_in_pos(sync_in_pos),
        .sync_in_neg(sync_in_neg), .cfg_load(cfg_load), .cfg_in(cfg_in),
        .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .lane_code(lane_code), .frame_start(frame_start), .link_state(link_state),
        .clkdiv_rst(clkdiv_rst), .cfg_active(cfg_active));
    jt_rx_model u_jt_rx_model (.clk(clk), .sys_rst(sys_rst), .lane_code(lane_code),
        .hold_req(hold_req), .sync_in_pos(sync_in_pos), .sync_in_neg(sync_in_neg));
    // Rising samples give every frame different end octets
    always @(posedge clk) begin
        if (inc_mode && sample_valid && sample_ready) begin
            sample_data <= sample_data + 14'h0001;
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic int k28(input logic [9:0] cd);
        for (int y = 0; y < 8; y++) begin
            if ((cd[9:4] === 6'h0F && cd[3:0] === jt_pkg::TAB4K[y]) ||
                (cd[9:4] === 6'h30 && cd[3:0] === ~jt_pkg::TAB4K[y])) begin
                return y;
            end
        end
        return 8;
    endfunction : k28
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic load(input jt_pkg::jt_cfg_type v);
        @(posedge clk);
        cfg_in <= v;
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
        @(negedge clk);
        check(48'(cfg_active), 48'(v));
    endtask : load
    // Mode 0 alignment only, 1 distinct frames, 2 repeated frames
    task automatic run_ila(input int mode);
        int f, kf, y, e, j, last, n;
        @(posedge clk);
        hold_req <= 1'b1;
        repeat (8) @(negedge clk);
        check(48'(link_state), 48'(jt_pkg::ST_CGS));
        check(48'(lane_code[9:3] == 7'h1F || lane_code[9:3] == 7'h60), 48'h1);
        @(posedge clk);
        hold_req <= 1'b0;
        f = int'(cfg_active.f_m1) + 1;
        kf = f * (int'(cfg_active.k_m1) + 1);
        last = -1;
        for (n = 0; n < 40 && link_state !== jt_pkg::ST_ILA; n++) @(negedge clk);
        check(48'(link_state), 48'(jt_pkg::ST_ILA));
        // Fixed two-edge depth from state change to first marker
        repeat (2) @(negedge clk);
        for (int i = 0; i < 6 * kf; i++) begin
            y = k28(lane_code);
            if (i < 4 * kf) begin
                e = (i % kf == 0) ? 0 : (i % kf == kf - 1) ? 3 :
                    (i / kf == 1 && i % kf == 1) ? 4 : 8;
                check(48'(y), 48'(e));
            end else begin
                j = i - 4 * kf;
                if (j == 0) check(48'(link_state), 48'(jt_pkg::ST_DATA));
                if (frame_start === 1'b1) begin
                    if (last >= 0) check(48'(j - last), 48'(f));
                    last = j;
                end
                e = (j % f != f - 1 || mode != 2) ? 8 :
                    (j % kf == kf - 1 && cfg_active.lane_sync_en) ? 3 : 7;
                // Early frames skip the check: the first end octet meets a zeroed prev_reg
                if (mode != 0 && j >= 3 * f) check(48'(y), 48'(e));
            end
            @(negedge clk);
        end
        check(48'(last >= 0), 48'h1);
    endtask : run_ila
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #500000;
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check(48'(link_state), 48'(jt_pkg::ST_CGS));
        check(48'({sample_ready, frame_start, clkdiv_rst}), 48'h0);
        check(48'(cfg_active), 48'(jt_pkg::CFG_RESET));
        $display("Test reset done");
        run_ila(2);
        $display("Test efficient repeated frames done");
        c = jt_pkg::CFG_RESET;
        c.simple = 1'b1;
        c.f_m1 = 8'h01;
        c.k_m1 = 5'h07;
        c.s_m1 = 8'h00;
        c.lanes_m1 = 5'h01;
        load(c);
        inc_mode <= 1'b1;
        run_ila(1);
        $display("Test simple distinct frames done");
        c.lane_sync_en = 1'b0;
        load(c);
        inc_mode <= 1'b0;
        run_ila(2);
        $display("Test simple without lane sync done");
        c = jt_pkg::CFG_RESET;
        c.scr_en = 1'b1;
        load(c);
        inc_mode <= 1'b1;
        run_ila(0);
        $display("Test scrambled alignment done");
        c.sync_is_divrst = 1'b1;
        load(c);
        @(posedge clk);
        hold_req <= 1'b1;
        repeat (4) @(negedge clk);
        check(48'(clkdiv_rst), 48'h1);
        check(48'(link_state), 48'(jt_pkg::ST_DATA));
        @(posedge clk);
        hold_req <= 1'b0;
        repeat (4) @(negedge clk);
        check(48'(clkdiv_rst), 48'h0);
        $display("Test divider reset done");
        test_done();
    end
endmodule : test_jt_link_tx
